/* File: src/pbm_pkg.sv */
// pbm_pkg: constants of both ends
// assumes one clock, 8 Kbyte byte-wide memory
//
// How it works
// - receive area spans start..end bounds inclusive
// - receive bytes consecutive, wrap end to start
// - host changes rx bounds only while disabled
// - bounds may straddle top-to-zero seam
// - fill position updated per good packet
// - receive never writes at the guard pointer
// - full FIFO drops new data, keeps old
// - host advances guard after processing packets
// - memory outside receive area is transmit space
// - host loads tx bounds before each send
// - no tx overlap check in the device
// - host refuses send overlapping receive area
// - separate host read and write pointers
// - host reads wrap at receive end bound
// - host writes increment linearly, no wrap
// - dma reads for checksum, reads/writes for copy
// - dma reads wrap, dma writes never wrap
// - step enable advances host pointers per data access
`default_nettype none

package pbm_pkg;
    localparam int PBM_AW = 13;
    localparam int PBM_MEM_BYTES = 8192;
    localparam logic [12:0] PBM_PTR_ONE = 13'h0001;
    localparam logic [12:0] PBM_PTR_RST = 13'h0000;
    // gap kept between tx end and rx area
    localparam logic [12:0] PBM_TX_GAP = 13'h0008;
    // register word indices
    localparam logic [3:0] PBM_IDX_CTRL = 4'h0;
    localparam logic [3:0] PBM_IDX_RXS = 4'h1;
    localparam logic [3:0] PBM_IDX_RXE = 4'h2;
    localparam logic [3:0] PBM_IDX_GUARD = 4'h3;
    localparam logic [3:0] PBM_IDX_TXS = 4'h4;
    localparam logic [3:0] PBM_IDX_TXE = 4'h5;
    localparam logic [3:0] PBM_IDX_HRD = 4'h6;
    localparam logic [3:0] PBM_IDX_HWR = 4'h7;
    localparam logic [3:0] PBM_IDX_FILL = 4'h8;
    localparam logic [3:0] PBM_IDX_DATA = 4'h9;
    localparam logic [3:0] PBM_IDX_STATUS = 4'hA;
    // control word fields
    localparam int PBM_CTRL_RECEIVE_ENABLE_FLAG = 0;
    localparam int PBM_CTRL_STEP = 1;
    localparam int PBM_CTRL_GO = 2;
    localparam logic PBM_RECEIVE_ENABLE_FLAG_RST = 1'b0;
    localparam logic PBM_STEP_RST = 1'b1;
    localparam int PBM_STAT_REFUSED = 0;

    typedef enum logic [1:0] {
        PBM_OP_WPTR,
        PBM_OP_RPTR,
        PBM_OP_RBUF,
        PBM_OP_WBUF
    } pbm_op_t;
endpackage : pbm_pkg

`default_nettype wire

/* File: src/pbm_link_if.sv */
// pbm_link_if: command link between the ends
// assumes both ends share clk_sys_in; one answer per command
`default_nettype none

interface pbm_link_if;
    import pbm_pkg::*;
    logic        cmd_valid;
    pbm_op_t     cmd_op;
    logic [3:0]  cmd_sel;
    logic [12:0] cmd_data;
    logic        rsp_valid;
    logic [12:0] rsp_data;

    modport host (
        output cmd_valid,
        output cmd_op,
        output cmd_sel,
        output cmd_data,
        input  rsp_valid,
        input  rsp_data
    );
    modport dev (
        input  cmd_valid,
        input  cmd_op,
        input  cmd_sel,
        input  cmd_data,
        output rsp_valid,
        output rsp_data
    );
endinterface : pbm_link_if

`default_nettype wire

/* File: src/pbm_ptr_step.sv */
// pbm_ptr_step: next address, wrapping in the rx area
// assumes bounds are stable while the pointer moves
`default_nettype none

module pbm_ptr_step
    import pbm_pkg::*;
(
    // pointer and bounds
    input  wire logic [12:0] ptr_in,
    input  wire logic [12:0] start_in,
    input  wire logic [12:0] end_in,
    // next address
    output logic      [12:0] next_out
);
    // 13-bit add rolls 1FFF to 0000 on its own
    always_comb
    begin
        if (ptr_in == end_in)
            next_out = start_in;
        else
            next_out = ptr_in + PBM_PTR_ONE;
    end
endmodule : pbm_ptr_step

`default_nettype wire

/* File: src/pbm_device.sv */
// pbm_device: packet memory with receive fifo, tx, host and dma paths
// assumes the controller keeps rx bounds still while receiving
`default_nettype none

module pbm_device
    import pbm_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    // controller link
    pbm_link_if.dev          link,
    // receive datapath
    input  wire logic        rx_valid_in,
    input  wire logic [7:0]  rx_data_in,
    input  wire logic        rx_last_in,
    input  wire logic        rx_good_in,
    output logic             rx_commit_out,
    output logic             rx_drop_out,
    // transmitter
    input  wire logic        tx_rd_en_in,
    input  wire logic [12:0] tx_rd_addr_in,
    output logic      [7:0]  tx_rd_data_out,
    output logic             tx_go_out,
    output logic      [12:0] tx_start_out,
    output logic      [12:0] tx_end_out,
    // dma engine
    input  wire logic        dma_rd_load_in,
    input  wire logic        dma_wr_load_in,
    input  wire logic [12:0] dma_addr_in,
    input  wire logic        dma_rd_en_in,
    output logic      [7:0]  dma_rd_data_out,
    input  wire logic        dma_wr_en_in,
    input  wire logic [7:0]  dma_wr_data_in
);
    logic [7:0]  mem [PBM_MEM_BYTES];
    logic [12:0] rx_start_q;
    logic [12:0] rx_end_q;
    logic [12:0] guard_q;
    logic [12:0] tx_start_q;
    logic [12:0] tx_end_q;
    logic [12:0] host_rd_q;
    logic [12:0] host_wr_q;
    logic [12:0] fill_q;
    logic [12:0] rx_wr_q;
    logic [12:0] dma_rd_q;
    logic [12:0] dma_wr_q;
    logic        rx_en_q;
    logic        step_en_q;
    logic        rx_dropping_q;
    logic        rsp_valid_q;
    logic [12:0] rsp_data_q;
    logic        commit_q;
    logic        drop_q;
    logic        go_q;
    logic [7:0]  tx_data_q;
    logic [7:0]  dma_data_q;
    logic [12:0] rx_next;
    logic [12:0] hrd_next;
    logic [12:0] dma_next;
    logic        rx_room;
    logic        rx_take;
    logic        rx_pkt_ok;
    logic        host_rbuf;
    logic        host_wbuf;
    logic        ctrl_wr;

    function automatic logic wsel(input logic [3:0] want);
        wsel = link.cmd_valid && (link.cmd_op == PBM_OP_WPTR)
            && (link.cmd_sel == want);
    endfunction : wsel

    pbm_ptr_step u_rx_step (
        .ptr_in   (rx_wr_q),
        .start_in (rx_start_q),
        .end_in   (rx_end_q),
        .next_out (rx_next)
    );
    pbm_ptr_step u_hrd_step (
        .ptr_in   (host_rd_q),
        .start_in (rx_start_q),
        .end_in   (rx_end_q),
        .next_out (hrd_next)
    );
    pbm_ptr_step u_dma_step (
        .ptr_in   (dma_rd_q),
        .start_in (rx_start_q),
        .end_in   (rx_end_q),
        .next_out (dma_next)
    );

    assign host_rbuf = link.cmd_valid && (link.cmd_op == PBM_OP_RBUF);
    assign host_wbuf = link.cmd_valid && (link.cmd_op == PBM_OP_WBUF);
    assign ctrl_wr = wsel(PBM_IDX_CTRL);
    // receive never writes the guard slot itself; host and dma writes ignore it
    assign rx_room = (rx_wr_q != guard_q);
    assign rx_take = rx_en_q && rx_valid_in && !rx_dropping_q && rx_room;
    assign rx_pkt_ok = rx_good_in && !rx_dropping_q && rx_room;

    // bounds and tx window
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rx_start_q <= PBM_PTR_RST;
            rx_end_q   <= PBM_PTR_RST;
            guard_q    <= PBM_PTR_RST;
            tx_start_q <= PBM_PTR_RST;
            tx_end_q   <= PBM_PTR_RST;
        end
        else
        begin
            if (wsel(PBM_IDX_RXS))
                rx_start_q <= link.cmd_data;
            if (wsel(PBM_IDX_RXE))
                rx_end_q <= link.cmd_data;
            if (wsel(PBM_IDX_GUARD))
                guard_q <= link.cmd_data;
            // no overlap
            if (wsel(PBM_IDX_TXS))
                tx_start_q <= link.cmd_data;
            if (wsel(PBM_IDX_TXE))
                tx_end_q <= link.cmd_data;
        end
    end

    // control bits and the one-cycle send strobe
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rx_en_q   <= PBM_RECEIVE_ENABLE_FLAG_RST;
            step_en_q <= PBM_STEP_RST;
            go_q      <= 1'b0;
        end
        else
        begin
            go_q <= ctrl_wr && link.cmd_data[PBM_CTRL_GO];
            if (ctrl_wr)
            begin
                rx_en_q   <= link.cmd_data[PBM_CTRL_RECEIVE_ENABLE_FLAG];
                step_en_q <= link.cmd_data[PBM_CTRL_STEP];
            end
        end
    end

    // host buffer pointers, independent read and write
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            host_rd_q <= PBM_PTR_RST;
            host_wr_q <= PBM_PTR_RST;
        end
        else
        begin
            if (wsel(PBM_IDX_HRD))
                host_rd_q <= link.cmd_data;
            else if (host_rbuf && step_en_q)
                host_rd_q <= hrd_next;
            if (wsel(PBM_IDX_HWR))
                host_wr_q <= link.cmd_data;
            else if (host_wbuf && step_en_q)
                host_wr_q <= host_wr_q + PBM_PTR_ONE;
        end
    end

    // receive write pointer and committed fill position
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rx_wr_q  <= PBM_PTR_RST;
            fill_q   <= PBM_PTR_RST;
            commit_q <= 1'b0;
            drop_q   <= 1'b0;
        end
        else
        begin
            commit_q <= 1'b0;
            drop_q   <= 1'b0;
            if (ctrl_wr && link.cmd_data[PBM_CTRL_RECEIVE_ENABLE_FLAG] && !rx_en_q)
            begin
                rx_wr_q <= rx_start_q;
                fill_q  <= rx_start_q;
            end
            else if (rx_en_q && rx_valid_in && rx_last_in)
            begin
                if (rx_pkt_ok)
                begin
                    rx_wr_q  <= rx_next;
                    fill_q   <= rx_next;
                    commit_q <= 1'b1;
                end
                else
                begin
                    // rewind: bad or cut packet leaves no trace
                    rx_wr_q <= fill_q;
                    drop_q  <= 1'b1;
                end
            end
            else if (rx_take)
                rx_wr_q <= rx_next;
        end
    end

    // once full, rest of the packet is thrown away
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rx_dropping_q <= 1'b0;
        else if (!rx_en_q || (rx_valid_in && rx_last_in))
            rx_dropping_q <= 1'b0;
        else if (rx_valid_in && !rx_room)
            rx_dropping_q <= 1'b1;
    end

    // dma pointers: reads wrap, writes run straight
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            dma_rd_q <= PBM_PTR_RST;
            dma_wr_q <= PBM_PTR_RST;
        end
        else
        begin
            if (dma_rd_load_in)
                dma_rd_q <= dma_addr_in;
            else if (dma_rd_en_in)
                dma_rd_q <= dma_next;
            if (dma_wr_load_in)
                dma_wr_q <= dma_addr_in;
            else if (dma_wr_en_in)
                dma_wr_q <= dma_wr_q + PBM_PTR_ONE;
        end
    end

    // one array for all; rx, host and dma may write in the same cycle
    always_ff @(posedge clk_sys_in)
    begin
        if (rx_take)
            mem[rx_wr_q] <= rx_data_in;
        if (host_wbuf)
            mem[host_wr_q] <= link.cmd_data[7:0];
        if (dma_wr_en_in)
            mem[dma_wr_q] <= dma_wr_data_in;
    end

    // registered read ports; any address outside rx is tx space
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tx_data_q  <= 8'h00;
            dma_data_q <= 8'h00;
        end
        else
        begin
            if (tx_rd_en_in)
                tx_data_q <= mem[tx_rd_addr_in];
            if (dma_rd_en_in)
                dma_data_q <= mem[dma_rd_q];
        end
    end

    // every command answered one cycle later
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= PBM_PTR_RST;
        end
        else
        begin
            rsp_valid_q <= link.cmd_valid;
            rsp_data_q  <= PBM_PTR_RST;
            if (host_rbuf)
                rsp_data_q <= {5'h00, mem[host_rd_q]};
            else if (link.cmd_valid && link.cmd_op == PBM_OP_RPTR)
            begin
                unique case (link.cmd_sel)
                    PBM_IDX_CTRL:
                        rsp_data_q <= {11'h000, step_en_q, rx_en_q};
                    PBM_IDX_RXS:   rsp_data_q <= rx_start_q;
                    PBM_IDX_RXE:   rsp_data_q <= rx_end_q;
                    PBM_IDX_GUARD: rsp_data_q <= guard_q;
                    PBM_IDX_TXS:   rsp_data_q <= tx_start_q;
                    PBM_IDX_TXE:   rsp_data_q <= tx_end_q;
                    PBM_IDX_HRD:   rsp_data_q <= host_rd_q;
                    PBM_IDX_HWR:   rsp_data_q <= host_wr_q;
                    PBM_IDX_FILL:  rsp_data_q <= fill_q;
                    default:       rsp_data_q <= PBM_PTR_RST;
                endcase
            end
        end
    end

    assign link.rsp_valid  = rsp_valid_q;
    assign link.rsp_data   = rsp_data_q;
    assign rx_commit_out   = commit_q;
    assign rx_drop_out     = drop_q;
    assign tx_rd_data_out  = tx_data_q;
    assign tx_go_out       = go_q;
    assign tx_start_out    = tx_start_q;
    assign tx_end_out      = tx_end_q;
    assign dma_rd_data_out = dma_data_q;
endmodule : pbm_device

`default_nettype wire

/* File: src/pbm_host.sv */
// pbm_host: apb slave issuing link commands
// assumes a well-behaved apb master; device answers every command
`default_nettype none

module pbm_host
    import pbm_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // device link
    pbm_link_if.host         link
);
    typedef enum logic {PBM_HS_IDLE, PBM_HS_WAIT} pbm_hstate_t;

    pbm_hstate_t state_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        cmd_valid_q;
    pbm_op_t     cmd_op_q;
    logic [3:0]  cmd_sel_q;
    logic [12:0] cmd_data_q;
    logic        sh_rx_en_q;
    logic [12:0] sh_rxs_q;
    logic [12:0] sh_rxe_q;
    logic [12:0] sh_txs_q;
    logic [12:0] sh_txe_q;
    logic        refused_q;
    logic [3:0]  idx;
    logic        hit;
    logic        acc;
    logic        tx_bad;
    logic        refuse;
    logic        local_acc;

    function automatic logic in_rx(input logic [12:0] a, input logic [12:0] s,
                                   input logic [12:0] e);
        if (s <= e)
            in_rx = (a >= s) && (a <= e);
        else
            in_rx = (a >= s) || (a <= e); // area across the seam
    endfunction : in_rx

    assign idx = paddr_in[5:2];
    assign hit = (paddr_in[11:6] == 6'h00) && (idx <= PBM_IDX_STATUS);
    assign acc = psel_in && penable_in && !pready_q && (state_q == PBM_HS_IDLE);
    assign tx_bad = in_rx(sh_txs_q, sh_rxs_q, sh_rxe_q)
        || in_rx(sh_txe_q, sh_rxs_q, sh_rxe_q)
        || in_rx(sh_txe_q + PBM_TX_GAP, sh_rxs_q, sh_rxe_q);
    assign refuse = pwrite_in && (
        (((idx == PBM_IDX_RXS) || (idx == PBM_IDX_RXE)) && sh_rx_en_q)
        || ((idx == PBM_IDX_CTRL) && pwdata_in[PBM_CTRL_GO] && tx_bad)
        || (idx == PBM_IDX_FILL));
    assign local_acc = !hit || refuse || (idx == PBM_IDX_STATUS);

    // apb answer and command issue
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_q     <= PBM_HS_IDLE;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            prdata_q    <= 32'h0000_0000;
            cmd_valid_q <= 1'b0;
            cmd_op_q    <= PBM_OP_RPTR;
            cmd_sel_q   <= 4'h0;
            cmd_data_q  <= PBM_PTR_RST;
        end
        else
        begin
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            cmd_valid_q <= 1'b0;
            unique case (state_q)
                PBM_HS_IDLE:
                begin
                    if (acc && local_acc)
                    begin
                        pready_q  <= 1'b1;
                        pslverr_q <= !hit || refuse;
                        prdata_q  <= (hit && idx == PBM_IDX_STATUS && !pwrite_in) ?
                            {31'h0000_0000, refused_q} : 32'h0000_0000;
                    end
                    else if (acc)
                    begin
                        cmd_valid_q <= 1'b1;
                        cmd_sel_q   <= idx;
                        cmd_data_q  <= pwdata_in[12:0];
                        if (idx == PBM_IDX_DATA)
                            cmd_op_q <= pwrite_in ? PBM_OP_WBUF : PBM_OP_RBUF;
                        else
                            cmd_op_q <= pwrite_in ? PBM_OP_WPTR : PBM_OP_RPTR;
                        state_q <= PBM_HS_WAIT;
                    end
                end
                PBM_HS_WAIT:
                begin
                    if (link.rsp_valid)
                    begin
                        pready_q <= 1'b1;
                        prdata_q <= {19'h0_0000, link.rsp_data};
                        state_q  <= PBM_HS_IDLE;
                    end
                end
            endcase
        end
    end

    // shadow copies of what the device was told
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sh_rx_en_q <= PBM_RECEIVE_ENABLE_FLAG_RST;
            sh_rxs_q   <= PBM_PTR_RST;
            sh_rxe_q   <= PBM_PTR_RST;
            sh_txs_q   <= PBM_PTR_RST;
            sh_txe_q   <= PBM_PTR_RST;
        end
        else if (acc && !local_acc && pwrite_in)
        begin
            if (idx == PBM_IDX_CTRL)
                sh_rx_en_q <= pwdata_in[PBM_CTRL_RECEIVE_ENABLE_FLAG];
            if (idx == PBM_IDX_RXS)
                sh_rxs_q <= pwdata_in[12:0];
            if (idx == PBM_IDX_RXE)
                sh_rxe_q <= pwdata_in[12:0];
            if (idx == PBM_IDX_TXS)
                sh_txs_q <= pwdata_in[12:0];
            if (idx == PBM_IDX_TXE)
                sh_txe_q <= pwdata_in[12:0];
        end
    end

    // sticky refusal flag, write one to clear; a new refusal wins
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            refused_q <= 1'b0;
        else if (acc && hit && refuse)
            refused_q <= 1'b1;
        else if (acc && pwrite_in && idx == PBM_IDX_STATUS
                 && pwdata_in[PBM_STAT_REFUSED])
            refused_q <= 1'b0;
    end

    assign prdata_out    = prdata_q;
    assign pready_out    = pready_q;
    assign pslverr_out   = pslverr_q;
    assign link.cmd_valid = cmd_valid_q;
    assign link.cmd_op    = cmd_op_q;
    assign link.cmd_sel   = cmd_sel_q;
    assign link.cmd_data  = cmd_data_q;
endmodule : pbm_host

`default_nettype wire

/* File: bench/pbm_assertions.sv */
// pbm_assertions: link checker
// assumes one clock domain
`default_nettype none

module pbm_assertions
    import pbm_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    // link signals
    input  wire logic        cmd_valid,
    input  var  pbm_op_t     cmd_op,
    input  wire logic [3:0]  cmd_sel,
    input  wire logic [12:0] cmd_data,
    input  wire logic        rsp_valid,
    input  wire logic [12:0] rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] guard_q;
    logic [12:0] hwr_q;
    logic        step_q;
    logic        wr_c;
    logic        rd_c;
    assign wr_c = cmd_valid && cmd_op == PBM_OP_WPTR;
    assign rd_c = cmd_valid && cmd_op == PBM_OP_RPTR;
    // shadows from the link alone
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            guard_q <= PBM_PTR_RST;
            hwr_q <= PBM_PTR_RST;
            step_q <= PBM_STEP_RST;
        end
        else
        begin
            if (wr_c && cmd_sel == PBM_IDX_GUARD) guard_q <= cmd_data;
            if (wr_c && cmd_sel == PBM_IDX_CTRL) step_q <= cmd_data[PBM_CTRL_STEP];
            if (wr_c && cmd_sel == PBM_IDX_HWR) hwr_q <= cmd_data;
            else if (cmd_valid && cmd_op == PBM_OP_WBUF && step_q) hwr_q <= hwr_q + PBM_PTR_ONE;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    sequence s_rbuf;
        cmd_valid && cmd_op == PBM_OP_RBUF;
    endsequence
    sequence s_byte;
        rsp_valid && rsp_data[12:8] == 5'h00;
    endsequence
    a_rsp_one_later: assert property (cmd_valid |=> rsp_valid)
        else $error("no answer");
    a_rsp_no_cmd: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("stray answer");
    a_cmd_spaced: assert property (cmd_valid |=> !cmd_valid [*3])
        else $error("commands too close");
    a_wr_rsp_zero: assert property (cmd_valid && cmd_op inside {PBM_OP_WPTR, PBM_OP_WBUF}
        |=> rsp_data == 13'h0000) else $error("write answer not zero");
    a_byte_narrow: assert property (s_rbuf |=> s_byte)
        else $error("byte not zero extended");
    a_guard_back: assert property (rd_c && cmd_sel == PBM_IDX_GUARD |=> rsp_data == guard_q)
        else $error("guard lost bits");
    a_hwr_linear: assert property (rd_c && cmd_sel == PBM_IDX_HWR |=> rsp_data == hwr_q)
        else $error("write pointer stepped wrongly");
    a_fill_ro: assert property (!(wr_c && cmd_sel == PBM_IDX_FILL))
        else $error("fill written");
endmodule : pbm_assertions

`default_nettype wire

/* File: bench/packet_buffer_pointer_manager_tb.sv */
// packet_buffer_pointer_manager_tb: both ends on one link
// assumes one 200 MHz clock; tx read port idle
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end

module packet_buffer_pointer_manager_tb
    import pbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [32:0] ALL = 33'h1FFFFFFFF;
    localparam logic [32:0] ERR = 33'h100000000;
    logic clk_sys_in, resetn_in, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, s;
    logic rx_valid, rx_last, rx_good, rx_commit, rx_drop, tx_go, dma_rl, dma_wl, dma_re, dma_we;
    logic [7:0] rx_data, dma_rd, dma_wd, tx_rd;
    logic [12:0] dma_a, tx_s, tx_e;
    logic [7:0] b[8];
    logic [32:0] qa[$], qm[$];
    logic [1:0] qr[$];
    logic [7:0] qd[$];
    logic dre_q;
    int n_mismatch, samples_checked;
    pbm_link_if lk();
    pbm_host u_pbm_host(.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(lk));
    pbm_device u_pbm_device(.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .link(lk),
        .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_last_in(rx_last),
        .rx_good_in(rx_good), .rx_commit_out(rx_commit), .rx_drop_out(rx_drop),
        .tx_rd_en_in(1'b0), .tx_rd_addr_in(13'h0000), .tx_rd_data_out(tx_rd),
        .tx_go_out(tx_go), .tx_start_out(tx_s), .tx_end_out(tx_e), .dma_rd_load_in(dma_rl),
        .dma_wr_load_in(dma_wl), .dma_addr_in(dma_a), .dma_rd_en_in(dma_re),
        .dma_rd_data_out(dma_rd), .dma_wr_en_in(dma_we), .dma_wr_data_in(dma_wd));
    pbm_assertions u_pbm_assertions(.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .cmd_valid(lk.cmd_valid), .cmd_op(lk.cmd_op), .cmd_sel(lk.cmd_sel),
        .cmd_data(lk.cmd_data), .rsp_valid(lk.rsp_valid), .rsp_data(lk.rsp_data));
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs
    task automatic results();
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    // idle edge between accesses
    task automatic apb(input logic w, input logic [3:0] i, input logic [31:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        qa.push_back(e & m);
        qm.push_back(m);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {6'h00, i, 2'b00};
        pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do @(posedge clk_sys_in); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_in);
    endtask : apb
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        apb(1'b1, i, d, 33'h000000000, ERR);
    endtask : wr
    task automatic rd(input logic [3:0] i, input logic [31:0] e);
        apb(1'b0, i, 32'h00000000, {1'b0, e}, ALL);
    endtask : rd
    task automatic rxp(input int n, input logic [1:0] e);
        for (int k = 0; k < n; k++)
        begin
            rx_valid <= 1'b1;
            rx_data <= b[k];
            rx_last <= (k == n - 1);
            @(posedge clk_sys_in);
        end
        qr.push_back(e);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
    endtask : rxp
    // oldest note vs result
    always @(posedge clk_sys_in)
    begin
        dre_q <= dma_re;
        if (pready === 1'b1)
        begin
            `CHK("apb answer", qa[0], {pslverr, prdata} & qm[0])
            void'(qa.pop_front());
            void'(qm.pop_front());
        end
        if (rx_commit === 1'b1 || rx_drop === 1'b1)
        begin
            `CHK("rx outcome", qr[0], {rx_commit, rx_drop})
            void'(qr.pop_front());
        end
        if (dre_q === 1'b1)
        begin
            `CHK("dma byte", qd[0], dma_rd)
            void'(qd.pop_front());
        end
    end
    initial
    begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    initial
    begin
        #100000;
        n_mismatch++;
        results();
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, rx_valid, rx_data, rx_last} = '0;
        {dma_rl, dma_wl, dma_re, dma_we, dma_a, dma_wd, dre_q, resetn_in} = '0;
        rx_good = 1'b1;
        s = 32'd73;
        repeat (2) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        @(posedge clk_sys_in);
        rd(PBM_IDX_CTRL, 32'h2);
        rd(PBM_IDX_FILL, 32'h0);
        rd(PBM_IDX_STATUS, 32'h0);
        for (int k = 1; k < 8; k++)
        begin
            pwdata <= xs() & 32'h1FFF;
            @(posedge clk_sys_in);
            wr(4'(k), pwdata);
            rd(4'(k), pwdata);
        end
        apb(1'b0, 4'hB, 32'h0, ERR, ALL);
        apb(1'b1, PBM_IDX_FILL, 32'h5, ERR, ERR);
        wr(PBM_IDX_RXS, 32'h1FFC);
        wr(PBM_IDX_RXE, 32'h0003);
        wr(PBM_IDX_GUARD, 32'h0003);
        wr(PBM_IDX_CTRL, 32'h3);
        for (int k = 0; k < 8; k++) b[k] = xs() & 8'hFF;
        rxp(5, 2'b10);
        rd(PBM_IDX_FILL, 32'h1);
        rxp(4, 2'b01);
        rd(PBM_IDX_FILL, 32'h1);
        wr(PBM_IDX_HRD, 32'h1FFC);
        for (int k = 0; k < 8; k++) apb(1'b0, PBM_IDX_DATA, 32'h0, b[k], k < 5 ? ALL : ERR);
        rd(PBM_IDX_HRD, 32'h1FFC);
        apb(1'b1, PBM_IDX_RXS, 32'h0, ERR, ERR);
        rd(PBM_IDX_STATUS, 32'h1);
        wr(PBM_IDX_STATUS, 32'h1);
        rd(PBM_IDX_STATUS, 32'h0);
        wr(PBM_IDX_CTRL, 32'h1);
        wr(PBM_IDX_HWR, 32'h0003);
        wr(PBM_IDX_DATA, 32'h5A);
        rd(PBM_IDX_HWR, 32'h0003);
        wr(PBM_IDX_CTRL, 32'h3);
        wr(PBM_IDX_DATA, 32'h5A);
        wr(PBM_IDX_DATA, 32'hA5);
        rd(PBM_IDX_HWR, 32'h0005);
        qd.push_back(8'h5A);
        qd.push_back(b[0]);
        dma_a <= 13'h0003;
        dma_rl <= 1'b1;
        @(posedge clk_sys_in);
        dma_rl <= 1'b0;
        dma_re <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        dma_re <= 1'b0;
        dma_wl <= 1'b1;
        @(posedge clk_sys_in);
        dma_wl <= 1'b0;
        dma_we <= 1'b1;
        dma_wd <= 8'hC3;
        @(posedge clk_sys_in);
        dma_wd <= 8'h3C;
        @(posedge clk_sys_in);
        dma_we <= 1'b0;
        wr(PBM_IDX_HRD, 32'h0004);
        rd(PBM_IDX_DATA, 32'h3C);
        repeat (4) @(posedge clk_sys_in);
        results();
    end
endmodule : packet_buffer_pointer_manager_tb

`default_nettype wire
